//--- verilog/alsic_pkg.sv
// Constants, field positions and types of the light sensor control block.
// Assumes a core clock of 200 MHz and a separate bus sampling clock.
// Behaviour
// - Answer only address 29h; 52h write, 53h read
// - Six command codes, each a 16-bit word
// - Bus clock from 10 to 400 kHz
// - Line low 25 to 35 ms abandons transfer
// - Shutdown holds last ambient result, still readable
// - Leaving shutdown, new measurements replace results
// - Code 01 holds upper window limit
// - Code 02 holds lower window limit
// - Code 04 returns ambient result, read only
// - Code 05 returns white result, read only
// - Status bit 15: crossed below lower limit
// - Status bit 14: crossed above upper limit
// - Bit 12 set reduces sensitivity to one eighth
// - Bit 11 set doubles result scale
// - Bit 10 set doubles amplifier gain
// - Bits 9:6 choose period 25 to 800 ms
// - Bits 5:4 repeat count 1, 2, 4, 8
// - Bit 3 picks compared channel, ambient or white
// - Bit 2 set runs the white channel too
// - Bit 1 enables threshold interrupts
// - Bit 0 set places device in shutdown
// - Alert pin only pulls low, else released
// - Flags and alert only while interrupts enabled
package alsic_pkg;
   localparam logic [6:0] DEV_ADDR = 7'h29;
   localparam logic [7:0] CMD_SETUP = 8'h00;
   localparam logic [7:0] CMD_UPPER = 8'h01;
   localparam logic [7:0] CMD_LOWER = 8'h02;
   localparam logic [7:0] CMD_AMBIENT = 8'h04;
   localparam logic [7:0] CMD_WHITE = 8'h05;
   localparam logic [7:0] CMD_FLAGS = 8'h06;
   localparam int BIT_RANGE_REDUCE = 12;
   localparam int BIT_DOUBLING = 11;
   localparam int BIT_GAIN = 10;
   localparam int BIT_PERIOD_HI = 9;
   localparam int BIT_PERIOD_LO = 6;
   localparam int BIT_REPEAT_HI = 5;
   localparam int BIT_REPEAT_LO = 4;
   localparam int BIT_SOURCE = 3;
   localparam int BIT_SECOND_PATH = 2;
   localparam int BIT_ALERT_ON = 1;
   localparam int BIT_POWER_DOWN = 0;
   localparam int BIT_FLAG_LOW = 15;
   localparam int BIT_FLAG_HIGH = 14;
   localparam logic [3:0] PERIOD_25 = 4'hC;
   localparam logic [3:0] PERIOD_50 = 4'h8;
   localparam logic [3:0] PERIOD_100 = 4'h0;
   localparam logic [3:0] PERIOD_200 = 4'h1;
   localparam logic [3:0] PERIOD_400 = 4'h2;
   localparam logic [3:0] PERIOD_800 = 4'h3;
   localparam logic [15:0] SETUP_RESET = 16'h0001;
   localparam logic [15:0] UPPER_RESET = 16'hFFFF;
   localparam logic [15:0] LOWER_RESET = 16'h0000;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [15:0] WORD_FULL = 16'hFFFF;
   localparam logic [3:0] BIT_CNT_ACK = 4'h8;
   localparam logic [3:0] BIT_CNT_HOST_ACK = 4'h9;
   localparam int BUS_CLK_MIN_KHZ = 10;
   localparam int BUS_CLK_MAX_KHZ = 400;
   localparam int CORE_CLK_KHZ = 200000;
   localparam int TIMEOUT_MIN_MS = 25;
   localparam int TIMEOUT_MAX_MS = 35;
   localparam int TIMEOUT_CYCLES = TIMEOUT_MIN_MS * CORE_CLK_KHZ;
   localparam int SHORTEST_PERIOD_MS = 25;
   localparam int SHORTEST_PERIOD_CYCLES = SHORTEST_PERIOD_MS * CORE_CLK_KHZ;
   typedef enum logic [4:0] {
      PH_IDLE = 5'b00001,
      PH_ADDR = 5'b00010,
      PH_CMD = 5'b00100,
      PH_WDATA = 5'b01000,
      PH_RDATA = 5'b10000
   } alsic_phase_type;
endpackage

//--- verilog/alsic_ctrl.sv
// Two-wire target port, register set, measurement timing and alert logic.
// Assumes link_clk oversamples the bus lines and raw channel counts come on core_clk.
`timescale 1ns/1ps
`default_nettype none
module alsic_ctrl
   import alsic_pkg::*;
#(
   parameter int TIMEOUT_CYC = TIMEOUT_CYCLES,
   parameter int SHORTEST_CYC = SHORTEST_PERIOD_CYCLES
) (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Analog front end counts
   input wire logic [15:0] ambient_raw,
   input wire logic [15:0] white_raw,
   // Bus sampling clock and lines
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Alert pin
   output logic alert_out,
   output logic alert_oe
);

   function automatic logic [15:0] scale_count(input logic [15:0] raw, input logic [15:0] setup);
      logic [17:0] v;
      v = {2'b00, raw};
      if (setup[BIT_RANGE_REDUCE]) begin
         v = v >> 3;
      end
      if (setup[BIT_DOUBLING]) begin
         v = v << 1;
      end
      if (setup[BIT_GAIN]) begin
         v = v << 1;
      end
      return (|v[17:16]) ? WORD_FULL : v[15:0];
   endfunction

   function automatic logic [2:0] period_shift(input logic [3:0] code);
      logic [2:0] s;
      unique case (code)
         PERIOD_25: s = 3'h0;
         PERIOD_50: s = 3'h1;
         PERIOD_100: s = 3'h2;
         PERIOD_200: s = 3'h3;
         PERIOD_400: s = 3'h4;
         PERIOD_800: s = 3'h5;
         default: s = 3'h2;
      endcase
      return s;
   endfunction

   // Link domain
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_q;
   logic sda_q;
   logic [1:0] stuck_sync;
   logic [2:0] pub_sync;
   alsic_phase_type phase;
   logic [3:0] bit_cnt;
   logic [7:0] shift_in;
   logic [7:0] cmd_code;
   logic [7:0] lo_hold;
   logic byte_hi;
   logic host_ack;
   logic sda_drive;
   logic [15:0] tx_word;
   logic [7:0] tx_byte;
   logic [15:0] light_setup;
   logic [15:0] upper_limit;
   logic [15:0] lower_limit;
   logic [15:0] ambient_link;
   logic [15:0] white_link;
   logic [1:0] flags_link;
   logic cfg_toggle;
   logic clr_toggle;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic fall_ack;
   logic read_hit;
   logic wr_commit;

   // Core domain
   logic [2:0] cfg_sync;
   logic [2:0] clr_sync;
   logic [1:0] scl_core;
   logic [1:0] sda_core;
   logic [31:0] low_cnt;
   logic stuck;
   logic [15:0] setup_core;
   logic [15:0] upper_core;
   logic [15:0] lower_core;
   logic [31:0] period_cnt;
   logic [31:0] period_len;
   logic meas_done;
   logic [15:0] ambient_result;
   logic [15:0] broadband_result;
   logic [15:0] next_ambient;
   logic [15:0] next_white;
   logic [15:0] compared;
   logic [3:0] repeat_cnt;
   logic [3:0] repeat_need;
   logic out_high;
   logic out_low;
   logic trip;
   logic flag_low;
   logic flag_high;
   logic clr_edge;
   logic pub_pending;
   logic pub_toggle;

   // Bus line sampling
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         scl_q <= scl_sync[1];
         sda_q <= sda_sync[1];
      end
   end

   // Crossings into the link domain
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         stuck_sync <= 2'b00;
         pub_sync <= 3'b000;
      end else begin
         stuck_sync <= {stuck_sync[0], stuck};
         pub_sync <= {pub_sync[1:0], pub_toggle};
      end
   end

   assign scl_rise = scl_sync[1] & ~scl_q;
   assign scl_fall = ~scl_sync[1] & scl_q;
   assign start_seen = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
   assign stop_seen = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
   assign fall_ack = scl_fall & (bit_cnt == BIT_CNT_ACK) & ~stuck_sync[1];
   assign read_hit = fall_ack & (phase == PH_ADDR) & (shift_in == {DEV_ADDR, 1'b1});
   assign wr_commit = fall_ack & (phase == PH_WDATA) & byte_hi;
   assign tx_byte = byte_hi ? tx_word[15:8] : tx_word[7:0];

   // Byte engine
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= PH_IDLE;
         bit_cnt <= 4'h0;
         shift_in <= 8'h00;
         cmd_code <= 8'h00;
         byte_hi <= 1'b0;
         host_ack <= 1'b0;
         sda_drive <= 1'b0;
      end else if (stuck_sync[1] || stop_seen) begin
         phase <= PH_IDLE;
         bit_cnt <= 4'h0;
         sda_drive <= 1'b0;
      end else if (start_seen) begin
         phase <= PH_ADDR;
         bit_cnt <= 4'h0;
         sda_drive <= 1'b0;
      end else if (scl_rise && phase != PH_IDLE) begin
         if (bit_cnt < BIT_CNT_ACK) begin
            shift_in <= {shift_in[6:0], sda_sync[1]};
         end else begin
            host_ack <= ~sda_sync[1];
         end
         bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_fall && phase != PH_IDLE) begin
         if (bit_cnt == BIT_CNT_ACK) begin
            unique case (phase)
               PH_ADDR: begin
                  if (shift_in[7:1] == DEV_ADDR) begin
                     sda_drive <= 1'b1;
                     phase <= shift_in[0] ? PH_RDATA : PH_CMD;
                     byte_hi <= 1'b0;
                  end else begin
                     phase <= PH_IDLE;
                  end
               end
               PH_CMD: begin
                  cmd_code <= shift_in;
                  sda_drive <= 1'b1;
                  phase <= PH_WDATA;
                  byte_hi <= 1'b0;
               end
               PH_WDATA: begin
                  sda_drive <= 1'b1;
                  byte_hi <= ~byte_hi;
               end
               default: begin
                  sda_drive <= 1'b0;
                  byte_hi <= ~byte_hi;
               end
            endcase
         end else if (bit_cnt == BIT_CNT_HOST_ACK) begin
            bit_cnt <= 4'h0;
            if (phase == PH_RDATA && host_ack) begin
               sda_drive <= ~tx_byte[7];
            end else if (phase == PH_RDATA) begin
               phase <= PH_IDLE;
               sda_drive <= 1'b0;
            end else begin
               sda_drive <= 1'b0;
            end
         end else if (phase == PH_RDATA) begin
            sda_drive <= ~tx_byte[3'(4'h7 - bit_cnt)];
         end
      end
   end

   // Read word selection and status read
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_word <= WORD_ZERO;
         clr_toggle <= 1'b0;
      end else if (read_hit) begin
         unique case (cmd_code)
            CMD_AMBIENT: tx_word <= ambient_link;
            CMD_WHITE: tx_word <= white_link;
            CMD_FLAGS: begin
               tx_word <= {flags_link, 14'h0000};
               clr_toggle <= ~clr_toggle;
            end
            default: tx_word <= WORD_ZERO;
         endcase
      end
   end

   // Host written words
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         light_setup <= SETUP_RESET;
         upper_limit <= UPPER_RESET;
         lower_limit <= LOWER_RESET;
         lo_hold <= 8'h00;
         cfg_toggle <= 1'b0;
      end else if (fall_ack && phase == PH_WDATA && !byte_hi) begin
         lo_hold <= shift_in;
      end else if (wr_commit) begin
         unique case (cmd_code)
            CMD_SETUP: light_setup <= {shift_in, lo_hold};
            CMD_UPPER: upper_limit <= {shift_in, lo_hold};
            CMD_LOWER: lower_limit <= {shift_in, lo_hold};
            default: lo_hold <= lo_hold;
         endcase
         cfg_toggle <= ~cfg_toggle;
      end
   end

   // Published results and flags
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         ambient_link <= WORD_ZERO;
         white_link <= WORD_ZERO;
         flags_link <= 2'b00;
      end else if (pub_sync[2] ^ pub_sync[1]) begin
         ambient_link <= ambient_result;
         white_link <= broadband_result;
         flags_link <= {flag_low, flag_high};
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_drive;

   // Crossings into the core domain
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_sync <= 3'b000;
         clr_sync <= 3'b000;
         scl_core <= 2'b11;
         sda_core <= 2'b11;
      end else begin
         cfg_sync <= {cfg_sync[1:0], cfg_toggle};
         clr_sync <= {clr_sync[1:0], clr_toggle};
         scl_core <= {scl_core[0], scl_in};
         sda_core <= {sda_core[0], sda_in};
      end
   end

   assign clr_edge = clr_sync[2] ^ clr_sync[1];

   // Configuration copy
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         setup_core <= SETUP_RESET;
         upper_core <= UPPER_RESET;
         lower_core <= LOWER_RESET;
      end else if (cfg_sync[2] ^ cfg_sync[1]) begin
         setup_core <= light_setup;
         upper_core <= upper_limit;
         lower_core <= lower_limit;
      end
   end

   // Stuck line timeout
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= 32'h0000_0000;
         stuck <= 1'b0;
      end else begin
         if (scl_core[1] && sda_core[1]) begin
            low_cnt <= 32'h0000_0000;
         end else if (low_cnt < 32'(TIMEOUT_CYC)) begin
            low_cnt <= low_cnt + 32'h0000_0001;
         end
         stuck <= (low_cnt >= 32'(TIMEOUT_CYC));
      end
   end

   // Measurement timebase
   assign period_len = 32'(SHORTEST_CYC) << period_shift(setup_core[BIT_PERIOD_HI:BIT_PERIOD_LO]);
   assign meas_done = ~setup_core[BIT_POWER_DOWN] && (period_cnt >= period_len - 32'h0000_0001);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         period_cnt <= 32'h0000_0000;
      end else if (setup_core[BIT_POWER_DOWN] || meas_done) begin
         period_cnt <= 32'h0000_0000;
      end else begin
         period_cnt <= period_cnt + 32'h0000_0001;
      end
   end

   // Result words
   assign next_ambient = scale_count(ambient_raw, setup_core);
   assign next_white = scale_count(white_raw, setup_core);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ambient_result <= WORD_ZERO;
         broadband_result <= WORD_ZERO;
      end else if (meas_done) begin
         ambient_result <= next_ambient;
         if (setup_core[BIT_SECOND_PATH]) begin
            broadband_result <= next_white;
         end
      end
   end

   // Window compare and repeat filter
   assign compared = setup_core[BIT_SOURCE] ? next_white : next_ambient;
   assign out_high = compared > upper_core;
   assign out_low = compared < lower_core;
   assign repeat_need = 4'h1 << setup_core[BIT_REPEAT_HI:BIT_REPEAT_LO];
   assign trip = meas_done && setup_core[BIT_ALERT_ON] && (out_high || out_low)
      && (repeat_cnt + 4'h1 >= repeat_need);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         repeat_cnt <= 4'h0;
      end else if (meas_done) begin
         if (setup_core[BIT_ALERT_ON] && (out_high || out_low)) begin
            if (repeat_cnt < repeat_need) begin
               repeat_cnt <= repeat_cnt + 4'h1;
            end
         end else begin
            repeat_cnt <= 4'h0;
         end
      end
   end

   // Crossing flags, set wins over clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_low <= 1'b0;
         flag_high <= 1'b0;
      end else begin
         flag_low <= (trip && out_low) || (flag_low && !clr_edge);
         flag_high <= (trip && out_high) || (flag_high && !clr_edge);
      end
   end

   // Publish to the link domain
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pub_pending <= 1'b0;
         pub_toggle <= 1'b0;
      end else begin
         pub_pending <= meas_done || clr_edge;
         if (pub_pending) begin
            pub_toggle <= ~pub_toggle;
         end
      end
   end

   // Open drain alert
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alert_oe <= 1'b0;
      end else begin
         alert_oe <= setup_core[BIT_ALERT_ON] && (flag_low || flag_high);
      end
   end

   assign alert_out = 1'b0;

endmodule
`default_nettype wire

//--- tb/alsic_ctrl_properties.sv
// Port-level checks of the light sensor control block.
// Assumes it is bound to alsic_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module alsic_ctrl_properties
   import alsic_pkg::*;
#(
   parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Raw counts
   input wire logic [15:0] ambient_raw,
   input wire logic [15:0] white_raw,
   // Bus
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Alert
   input wire logic alert_out,
   input wire logic alert_oe
);
   int low_cnt;
   // Core cycles with the bus clock line held low
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= 0;
      end else if (scl_in) begin
         low_cnt <= 0;
      end else if (low_cnt < TIMEOUT_CYC + 100) begin
         low_cnt <= low_cnt + 1;
      end
   end
   a_sda_drain_only:
      assert property (@(posedge link_clk) disable iff (!rst_n) sda_out == 1'b0)
      else $error("Data line driven high");
   a_alert_drain_only:
      assert property (@(posedge core_clk) disable iff (!rst_n) alert_out == 1'b0)
      else $error("Alert line driven high");
   a_ack_scl_low:
      assert property (@(posedge link_clk) disable iff (!rst_n) $rose(sda_oe) |-> !scl_in)
      else $error("Data pull started while clock high");
   a_release_scl_low:
      assert property (@(posedge link_clk) disable iff (!rst_n) $fell(sda_oe) |-> !scl_in)
      else $error("Data pull released while clock high");
   a_ack_holds:
      assert property (@(posedge link_clk) disable iff (!rst_n) $rose(sda_oe) |=> sda_oe [*8])
      else $error("Data pull too short");
   a_bus_timeout:
      assert property (@(posedge core_clk) disable iff (!rst_n) low_cnt >= TIMEOUT_CYC + 64 |-> !sda_oe)
      else $error("Transfer not abandoned after long low clock");
   a_alert_clear_bus:
      assert property (@(posedge core_clk) disable iff (!rst_n) $fell(alert_oe) |-> !scl_in)
      else $error("Alert released outside a bus access");
   a_alert_holds:
      assert property (@(posedge core_clk) disable iff (!rst_n) $rose(alert_oe) |=> alert_oe [*4])
      else $error("Alert pulse too short");
   c_alert: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(alert_oe));
   c_ack: cover property (@(posedge link_clk) disable iff (!rst_n) $rose(sda_oe));
   c_timeout: cover property (@(posedge core_clk) disable iff (!rst_n) low_cnt == TIMEOUT_CYC + 64);
endmodule
`default_nettype wire

//--- tb/alsic_host_model.sv
// Bus controller model: bit timing, bytes and word transfers.
// Assumes a pull-up on the data line; the target pulls it through dev_pull.
`timescale 1ns/1ps
`default_nettype none
module alsic_host_model (
   // Bus lines
   output logic scl,
   output wire logic sda,
   // Target pull
   input wire logic dev_pull
);
   localparam time HALF = 1250;
   localparam time QTR = 625;
   logic host_low = 1'b0;
   initial scl = 1'b1;
   assign sda = !(host_low || dev_pull);
   task automatic put_bit(input logic b);
      #QTR host_low = !b;
      #QTR scl = 1'b1;
      #HALF scl = 1'b0;
   endtask
   task automatic get_bit(output logic b);
      #QTR host_low = 1'b0;
      #QTR scl = 1'b1;
      #QTR b = sda;
      #QTR scl = 1'b0;
   endtask
   task automatic start();
      #QTR host_low = 1'b0;
      #QTR scl = 1'b1;
      #HALF host_low = 1'b1;
      #HALF scl = 1'b0;
   endtask
   task automatic stop();
      #QTR host_low = 1'b1;
      #QTR scl = 1'b1;
      #HALF host_low = 1'b0;
      #HALF;
   endtask
   task automatic send_byte(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) put_bit(v[i]);
      get_bit(ack);
      ack = !ack;
   endtask
   task automatic recv_byte(input logic last, output logic [7:0] v);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         get_bit(b);
         v[i] = b;
      end
      put_bit(last);
   endtask
   task automatic write_word(input logic [7:0] code, input logic [15:0] w, output logic ok);
      logic a0, a1, a2, a3;
      start();
      send_byte(8'h52, a0);
      send_byte(code, a1);
      send_byte(w[7:0], a2);
      send_byte(w[15:8], a3);
      stop();
      ok = a0 & a1 & a2 & a3;
   endtask
   task automatic read_word(input logic [7:0] code, output logic [15:0] w, output logic ok);
      logic a0, a1, a2;
      logic [7:0] lo, hi;
      start();
      send_byte(8'h52, a0);
      send_byte(code, a1);
      start();
      send_byte(8'h53, a2);
      recv_byte(1'b0, lo);
      recv_byte(1'b1, hi);
      stop();
      w = {hi, lo};
      ok = a0 & a1 & a2;
   endtask
endmodule
`default_nettype wire

//--- tb/alsic_ctrl_tb.sv
// Self-checking bench of the light sensor control block.
// Assumes the host model drives the bus and the bench drives the raw counts.
`timescale 1ns/1ps
`default_nettype none
module alsic_ctrl_tb
   import alsic_pkg::*;
   ;
   logic core_clk, link_clk, rst_n, scl, sda_out, sda_oe, alert_out, alert_oe;
   wire sda;
   logic [15:0] ambient_raw, white_raw;
   int bad_count = 0;
   int compares = 0;
   initial core_clk = 1'b0;
   always #2.5 core_clk = !core_clk;
   initial link_clk = 1'b0;
   always #32 link_clk = !link_clk;
   // Timeout must exceed the longest legal low data run (18 bits, 45 us at 400 kHz)
   alsic_ctrl #(.TIMEOUT_CYC(12000), .SHORTEST_CYC(200)) alsic_ctrl_i (
      .core_clk(core_clk), .rst_n(rst_n), .ambient_raw(ambient_raw), .white_raw(white_raw),
      .link_clk(link_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .alert_out(alert_out), .alert_oe(alert_oe));
   alsic_host_model alsic_host_model_i (.scl(scl), .sda(sda), .dev_pull(sda_oe));
   task automatic report_and_stop();
      $display("Compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic set_raw(input logic [15:0] a, input logic [15:0] w);
      @(posedge core_clk);
      #1;
      ambient_raw = a;
      white_raw = w;
   endtask
   task automatic wr(input logic [7:0] code, input logic [15:0] w);
      logic ok;
      alsic_host_model_i.write_word(code, w, ok);
      check({15'h0000, ok}, 16'h0001);
   endtask
   task automatic rd(input logic [7:0] code, output logic [15:0] w);
      logic ok;
      alsic_host_model_i.read_word(code, w, ok);
      check({15'h0000, ok}, 16'h0001);
   endtask
   task automatic t_foreign();
      logic ack;
      alsic_host_model_i.start();
      alsic_host_model_i.send_byte(8'h54, ack);
      alsic_host_model_i.stop();
      check({15'h0000, ack}, 16'h0000);
   endtask
   task automatic t_config();
      logic [15:0] v;
      set_raw(16'h1234, 16'h0ABC);
      wr(CMD_LOWER, 16'h0100);
      wr(CMD_UPPER, 16'h2000);
      wr(CMD_SETUP, 16'h0306);
      #5000;
      rd(CMD_AMBIENT, v);
      check(v, 16'h1234);
      rd(CMD_WHITE, v);
      check(v, 16'h0ABC);
   endtask
   task automatic t_high();
      logic [15:0] v;
      set_raw(16'h3000, 16'h0ABC);
      #3000;
      check({15'h0000, alert_oe}, 16'h0001);
      set_raw(16'h1234, 16'h0ABC);
      #3000;
      rd(CMD_FLAGS, v);
      check(v, 16'h4000);
      #1000;
      check({15'h0000, alert_oe}, 16'h0000);
   endtask
   task automatic t_low();
      logic [15:0] v;
      set_raw(16'h0050, 16'h0ABC);
      #3000;
      rd(CMD_FLAGS, v);
      check(v, 16'h8000);
      #3000;
      check({15'h0000, alert_oe}, 16'h0001);
      wr(CMD_SETUP, 16'h0304);
      #100;
      check({15'h0000, alert_oe}, 16'h0000);
   endtask
   task automatic t_timeout();
      logic [7:0] a;
      a = 8'h52;
      alsic_host_model_i.start();
      for (int i = 7; i >= 0; i--) alsic_host_model_i.put_bit(a[i]);
      #500;
      check({15'h0000, sda_oe}, 16'h0001);
      #70000;
      check({15'h0000, sda_oe}, 16'h0000);
      alsic_host_model_i.stop();
   endtask
   task automatic t_shutdown();
      logic [15:0] v;
      set_raw(16'h1111, 16'h0ABC);
      #3000;
      wr(CMD_SETUP, 16'h0305);
      set_raw(16'h2222, 16'h0ABC);
      #3000;
      rd(CMD_AMBIENT, v);
      check(v, 16'h1111);
      wr(CMD_SETUP, 16'h0B04);
      #3000;
      rd(CMD_AMBIENT, v);
      check(v, 16'h4444);
   endtask
   initial begin
      #3000000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0;
      ambient_raw = 16'h0000;
      white_raw = 16'h0000;
      repeat (6) @(posedge link_clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge link_clk);
      t_foreign();
      t_config();
      t_high();
      t_low();
      t_timeout();
      t_shutdown();
      report_and_stop();
   end
endmodule
bind alsic_ctrl alsic_ctrl_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) alsic_ctrl_properties_i (
   .core_clk(core_clk), .rst_n(rst_n), .ambient_raw(ambient_raw), .white_raw(white_raw),
   .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .alert_out(alert_out), .alert_oe(alert_oe));
`default_nettype wire
